// ### design/lso_frame_fifo_ctl.sv
// transmit frame fifo controller: large-send segmentation and fifo stop/flush
// assumes template bytes are loaded before job_start and payload follows it
// What this block does
// - per segment: ipv4 header, pseudo-header, tcp checksums
// - ip and tcp options copied unchanged
// - command word sets insert-fcs and pad
// - snap template: rewrite 802.3 length field
// - fragment fields and urg/rst/syn ignored
// - non-final ip length from mss and headers
// - first segment keeps template id and sequence
// - later segments increment ip identification
// - later segments advance sequence by mss
// - last payload is total minus n*mss
// - final segment copies template fin/psh
// - flush resets fifo read/write pointers
// - host stops and disables before flushing
// - flush bit self-clears when done
// - stopped irq holds until both disabled clear
// - finish current frame before reporting disabled
// - host stops fifo first, then mac
// - disabled condition shown as irq status
// - abort after disable drops the frame
// - restart mac then fifo; resume stored frames
// - host avoids flush with bulk pending
// - non-final segments carry exactly mss payload
// - host keeps template within 256 bytes
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
module lso_frame_fifo_ctl #(
	parameter int unsigned DEPTH = 4096
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// link to mac and controller
	lso_link_if.dev          link,
	// segmentation job
	input  wire logic        job_start,
	output logic             job_ready,
	input  wire logic [15:0] job_mss,
	input  wire logic [15:0] job_total,
	input  wire logic [7:0]  job_l2_len,
	input  wire logic [7:0]  job_vlan_len,
	input  wire logic [7:0]  job_ip_len,
	input  wire logic [7:0]  job_tcp_len,
	input  wire logic        job_ipv4,
	input  wire logic        job_snap,
	// template store
	input  wire logic        tpl_we,
	input  wire logic [7:0]  tpl_addr,
	input  wire logic [7:0]  tpl_data,
	// payload stream
	input  wire logic        pl_valid,
	output logic             pl_ready,
	input  wire logic [7:0]  pl_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	if (DEPTH < 1024 || (1 << AW) != DEPTH) begin : g_chk
		$error("DEPTH must be a power of two of at least 1024");
	end

	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		add16 = s[15:0] + {15'h0, s[16]};
	endfunction : add16

	function automatic logic [7:0] put16(input logic [7:0] cur, input logic [8:0] rel,
		input logic [8:0] o, input logic [15:0] v);
		put16 = (rel == o) ? v[15:8] : (rel == o + 9'h1) ? v[7:0] : cur;
	endfunction : put16

	logic [7:0]        tpl_mem [lso_pkg::TPL_BYTES];
	logic [8:0]        fifo_mem [DEPTH];
	lso_pkg::lso_seg_t st_reg;
	logic [15:0]       mss_reg, total_reg, nseg_reg, id_reg, seg_pay_reg, pay_cnt_reg;
	logic [15:0]       pay_acc_reg, ip_acc_reg, tcp_acc_reg;
	logic [31:0]       seq_reg;
	logic [7:0]        l2_reg, vlan_reg, iph_reg, tcph_reg;
	logic              v4_reg, snap_reg, last_reg;
	logic [8:0]        hcnt_reg;
	logic [AW:0]       wr_base_reg, commit_reg, rd_ptr_reg, fstart_reg;
	logic              ctl_en_reg, flush_reg, irq_sts_reg, irq_en_reg, dis_d_reg;
	logic              in_frame_reg, skip_reg, out_valid_reg, out_last_reg;
	logic [7:0]        out_data_reg;
	logic [31:0]       rdata_reg;

	logic [8:0]  ip_ofs, tcp_ofs, hdr_len, hpos, rel_ip, rel_tcp;
	logic [15:0] rem, pay_now, ip_len, frame_len, tcp_len, ip_csum, tcp_csum, sw;
	logic [31:0] cmd_word;
	logic [7:0]  gb;
	logic        wpass, in_ip, in_tcp, in_addr, disabled, rd_have, rd_take;
	logic [AW:0] used;
	logic [16:0] need;

	assign ip_ofs  = 9'(l2_reg) + 9'(vlan_reg);
	assign tcp_ofs = ip_ofs + 9'(iph_reg);
	assign hdr_len = tcp_ofs + 9'(tcph_reg);
	assign rem     = total_reg - 16'(nseg_reg * mss_reg);
	assign pay_now = (rem > mss_reg) ? mss_reg : rem;
	assign ip_len  = seg_pay_reg + 16'(iph_reg) + 16'(tcph_reg);
	assign frame_len = ip_len + 16'(ip_ofs);
	assign tcp_len = seg_pay_reg + 16'(tcph_reg);
	assign cmd_word = lso_pkg::CMDA_FCS | lso_pkg::CMDA_PAD | {16'h0, frame_len};
	assign used = wr_base_reg - rd_ptr_reg;
	assign need = 17'(lso_pkg::CMD_BYTES) + 17'(hdr_len) + 17'(pay_now);
	assign ip_csum = ~ip_acc_reg;
	assign tcp_csum = ~add16(add16(add16(tcp_acc_reg, pay_acc_reg), lso_pkg::PROTO_TCP),
		tcp_len);

	// header byte generator, shared by the checksum pass and the write pass
	assign wpass   = (st_reg == lso_pkg::SEG_HDR);
	assign hpos    = wpass ? hcnt_reg - lso_pkg::CMD_BYTES : hcnt_reg;
	assign rel_ip  = hpos - ip_ofs;
	assign rel_tcp = hpos - tcp_ofs;
	assign in_ip   = hpos >= ip_ofs && hpos < tcp_ofs;
	assign in_tcp  = hpos >= tcp_ofs;
	assign in_addr = in_ip && (v4_reg ? (rel_ip >= lso_pkg::V4_ADDR && rel_ip < lso_pkg::V4_AEND)
		: (rel_ip >= lso_pkg::V6_ADDR && rel_ip < lso_pkg::V6_AEND));
	always_comb begin
		gb = tpl_mem[hpos[7:0]];
		if (snap_reg)
			gb = put16(gb, hpos - 9'(vlan_reg), lso_pkg::ETH_LEN, ip_len);
		if (in_ip && v4_reg) begin
			gb = put16(gb, rel_ip, lso_pkg::V4_LEN, ip_len);
			gb = put16(gb, rel_ip, lso_pkg::V4_ID, id_reg);
			gb = put16(gb, rel_ip, lso_pkg::V4_CSUM, wpass ? ip_csum : 16'h0);
		end else if (in_ip)
			gb = put16(gb, rel_ip, lso_pkg::V6_LEN, tcp_len);
		if (in_tcp) begin
			gb = put16(gb, rel_tcp, lso_pkg::TCP_SEQ, seq_reg[31:16]);
			gb = put16(gb, rel_tcp, lso_pkg::TCP_SEQ + 9'h2, seq_reg[15:0]);
			gb = put16(gb, rel_tcp, lso_pkg::TCP_CSUM, wpass ? tcp_csum : 16'h0);
			if (rel_tcp == lso_pkg::TCP_FLG && !last_reg) begin
				gb[lso_pkg::TCP_FIN] = 1'b0;
				gb[lso_pkg::TCP_PSH] = 1'b0;
			end
		end
		sw = (in_tcp ? rel_tcp[0] : rel_ip[0]) ? {8'h0, gb} : {gb, 8'h0};
	end

	always_ff @(posedge hclk) begin
		if (tpl_we)
			tpl_mem[tpl_addr] <= tpl_data;
	end

	// fifo write port: payload first, then command word and headers in front of it
	always_ff @(posedge hclk) begin
		if (st_reg == lso_pkg::SEG_PAYLD && pl_valid)
			fifo_mem[AW'(wr_base_reg + (AW + 1)'(lso_pkg::CMD_BYTES) + (AW + 1)'(hdr_len)
				+ (AW + 1)'(pay_cnt_reg))] <= {pay_cnt_reg == seg_pay_reg - 16'h1, pl_data};
		else if (wpass)
			fifo_mem[AW'(wr_base_reg + (AW + 1)'(hcnt_reg))] <= {1'b0,
				(hcnt_reg < lso_pkg::CMD_BYTES) ? cmd_word[8 * hcnt_reg[1:0] +: 8] : gb};
	end

	assign job_ready = (st_reg == lso_pkg::SEG_IDLE);
	assign pl_ready  = (st_reg == lso_pkg::SEG_PAYLD);

	// segmentation sequence; the payload is stored first so the tcp checksum is known
	// before the headers are written, at the cost of a second pass over the header
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= lso_pkg::SEG_IDLE;
			{mss_reg, total_reg, nseg_reg, id_reg, seg_pay_reg, pay_cnt_reg} <= '0;
			{pay_acc_reg, ip_acc_reg, tcp_acc_reg, seq_reg} <= '0;
			{l2_reg, vlan_reg, iph_reg, tcph_reg, v4_reg, snap_reg, last_reg} <= '0;
			hcnt_reg <= '0;
			wr_base_reg <= '0;
			commit_reg <= '0;
		end else if (flush_reg) begin
			st_reg <= lso_pkg::SEG_IDLE;
			wr_base_reg <= '0;
			commit_reg <= '0;
		end else begin
			case (st_reg)
				lso_pkg::SEG_IDLE: if (job_start) begin
					{mss_reg, total_reg, nseg_reg} <= {job_mss, job_total, 16'h0};
					{l2_reg, vlan_reg, iph_reg, tcph_reg} <=
						{job_l2_len, job_vlan_len, job_ip_len, job_tcp_len};
					{v4_reg, snap_reg} <= {job_ipv4, job_snap};
					st_reg <= lso_pkg::SEG_ROOM;
				end
				lso_pkg::SEG_ROOM: begin
					if (nseg_reg == 16'h0) begin
						id_reg <= {tpl_mem[8'(ip_ofs + lso_pkg::V4_ID)],
							tpl_mem[8'(ip_ofs + lso_pkg::V4_ID + 9'h1)]};
						seq_reg <= {tpl_mem[8'(tcp_ofs + lso_pkg::TCP_SEQ)],
							tpl_mem[8'(tcp_ofs + lso_pkg::TCP_SEQ + 9'h1)],
							tpl_mem[8'(tcp_ofs + lso_pkg::TCP_SEQ + 9'h2)],
							tpl_mem[8'(tcp_ofs + lso_pkg::TCP_SEQ + 9'h3)]};
					end
					if (32'(DEPTH) - 32'(used) >= 32'(need) && pay_now != 16'h0) begin
						seg_pay_reg <= pay_now;
						last_reg <= (rem <= mss_reg);
						{pay_cnt_reg, pay_acc_reg} <= '0;
						st_reg <= lso_pkg::SEG_PAYLD;
					end else if (pay_now == 16'h0)
						st_reg <= lso_pkg::SEG_IDLE;
				end
				lso_pkg::SEG_PAYLD: if (pl_valid) begin
					pay_acc_reg <= add16(pay_acc_reg, pay_cnt_reg[0] ? {8'h0, pl_data}
						: {pl_data, 8'h0});
					pay_cnt_reg <= pay_cnt_reg + 16'h1;
					if (pay_cnt_reg == seg_pay_reg - 16'h1) begin
						{hcnt_reg, ip_acc_reg, tcp_acc_reg} <= '0;
						st_reg <= lso_pkg::SEG_SUM;
					end
				end
				lso_pkg::SEG_SUM: begin
					if (in_ip && v4_reg)
						ip_acc_reg <= add16(ip_acc_reg, sw);
					if (in_tcp || in_addr)
						tcp_acc_reg <= add16(tcp_acc_reg, sw);
					hcnt_reg <= hcnt_reg + 9'h1;
					if (hcnt_reg == hdr_len - 9'h1) begin
						hcnt_reg <= '0;
						st_reg <= lso_pkg::SEG_HDR;
					end
				end
				lso_pkg::SEG_HDR: begin
					hcnt_reg <= hcnt_reg + 9'h1;
					if (hcnt_reg == hdr_len + lso_pkg::CMD_BYTES - 9'h1)
						st_reg <= lso_pkg::SEG_DONE;
				end
				lso_pkg::SEG_DONE: begin
					wr_base_reg <= wr_base_reg + (AW + 1)'(lso_pkg::CMD_BYTES)
						+ (AW + 1)'(hdr_len) + (AW + 1)'(seg_pay_reg);
					commit_reg <= wr_base_reg + (AW + 1)'(lso_pkg::CMD_BYTES)
						+ (AW + 1)'(hdr_len) + (AW + 1)'(seg_pay_reg);
					nseg_reg <= nseg_reg + 16'h1;
					id_reg <= id_reg + 16'h1;
					seq_reg <= seq_reg + {16'h0, mss_reg};
					st_reg <= last_reg ? lso_pkg::SEG_IDLE : lso_pkg::SEG_ROOM;
				end
				default: st_reg <= lso_pkg::SEG_IDLE;
			endcase
		end
	end

	// read side toward the mac
	assign rd_have  = rd_ptr_reg != commit_reg;
	assign rd_take  = rd_have && !skip_reg && (!out_valid_reg || link.tx_ready)
		&& (in_frame_reg || ctl_en_reg);
	assign disabled = !ctl_en_reg && !in_frame_reg && !out_valid_reg && !skip_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rd_ptr_reg, fstart_reg} <= '0;
			{in_frame_reg, skip_reg, out_valid_reg, out_last_reg} <= '0;
			out_data_reg <= '0;
		end else if (flush_reg) begin
			{rd_ptr_reg, fstart_reg} <= '0;
			{in_frame_reg, skip_reg, out_valid_reg} <= '0;
		end else if (link.tx_abort && (in_frame_reg || out_valid_reg)) begin
			out_valid_reg <= 1'b0;
			in_frame_reg <= 1'b0;
			if (ctl_en_reg)
				rd_ptr_reg <= fstart_reg; // retry the frame from its command word
			else
				skip_reg <= in_frame_reg;
		end else if (skip_reg) begin
			if (rd_have) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				skip_reg <= !fifo_mem[AW'(rd_ptr_reg)][8];
			end
		end else begin
			if (rd_take) begin
				{out_last_reg, out_data_reg} <= fifo_mem[AW'(rd_ptr_reg)];
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				in_frame_reg <= !fifo_mem[AW'(rd_ptr_reg)][8];
				if (!in_frame_reg)
					fstart_reg <= rd_ptr_reg;
			end
			if (rd_take)
				out_valid_reg <= 1'b1;
			else if (link.tx_ready)
				out_valid_reg <= 1'b0;
		end
	end

	assign link.tx_valid = out_valid_reg;
	assign link.tx_data  = out_data_reg;
	assign link.tx_last  = out_last_reg;

	// register port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{ctl_en_reg, flush_reg, irq_en_reg} <= '0;
		end else begin
			if (link.reg_wr && link.reg_addr == lso_pkg::REG_TX_CTL)
				ctl_en_reg <= link.reg_wdata[lso_pkg::CTL_EN];
			if (link.reg_wr && link.reg_addr == lso_pkg::REG_TX_CTL
				&& link.reg_wdata[lso_pkg::CTL_FLUSH])
				flush_reg <= 1'b1;
			else if (flush_reg)
				flush_reg <= 1'b0;
			if (link.reg_wr && link.reg_addr == lso_pkg::REG_IRQ_EN)
				irq_en_reg <= link.reg_wdata[0];
		end
	end

	// the stopped flag is sticky: set on entry to disabled, released only once
	// both the fifo and the mac report running again; the set wins a tie
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sts_reg <= 1'b0;
			dis_d_reg <= 1'b0;
		end else begin
			dis_d_reg <= disabled;
			if (disabled && !dis_d_reg)
				irq_sts_reg <= 1'b1;
			else if (!disabled && !link.mac_tx_off)
				irq_sts_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_reg <= '0;
		else
			case (link.reg_addr)
				lso_pkg::REG_TX_CTL:  rdata_reg <= {29'h0, disabled, flush_reg, ctl_en_reg};
				lso_pkg::REG_IRQ_STS: rdata_reg <= {31'h0, irq_sts_reg};
				lso_pkg::REG_IRQ_EN:  rdata_reg <= {31'h0, irq_en_reg};
				default:              rdata_reg <= '0;
			endcase
	end

	assign link.reg_rdata = rdata_reg;
	assign link.irq = irq_sts_reg & irq_en_reg;
endmodule : lso_frame_fifo_ctl

// ### design/lso_pkg.sv
// constants shared by both ends of the transmit segmentation link
// assumes one clock domain, byte-wide frame link, 32-bit register words
package lso_pkg;
	// device register indices on the link register port
	localparam logic [1:0] REG_TX_CTL  = 2'h0;
	localparam logic [1:0] REG_IRQ_STS = 2'h1;
	localparam logic [1:0] REG_IRQ_EN  = 2'h2;
	localparam int unsigned CTL_EN    = 0;
	localparam int unsigned CTL_FLUSH = 1;
	localparam int unsigned CTL_DIS   = 2;
	// first command word of a generated frame
	localparam logic [31:0] CMDA_FCS = 32'h0040_0000;
	localparam logic [31:0] CMDA_PAD = 32'h0080_0000;
	localparam logic [8:0]  CMD_BYTES = 9'h004;
	// header field offsets, relative to the start of their header
	localparam logic [8:0] ETH_LEN  = 9'h00c;
	localparam logic [8:0] V4_LEN   = 9'h002;
	localparam logic [8:0] V4_ID    = 9'h004;
	localparam logic [8:0] V4_CSUM  = 9'h00a;
	localparam logic [8:0] V4_ADDR  = 9'h00c;
	localparam logic [8:0] V4_AEND  = 9'h014;
	localparam logic [8:0] V6_LEN   = 9'h004;
	localparam logic [8:0] V6_ADDR  = 9'h008;
	localparam logic [8:0] V6_AEND  = 9'h028;
	localparam logic [8:0] TCP_SEQ  = 9'h004;
	localparam logic [8:0] TCP_FLG  = 9'h00d;
	localparam logic [8:0] TCP_CSUM = 9'h010;
	localparam int unsigned TCP_FIN = 0;
	localparam int unsigned TCP_PSH = 3;
	localparam logic [15:0] PROTO_TCP = 16'h0006;
	localparam int unsigned TPL_BYTES = 256;
	// controller registers on AHB-Lite
	localparam logic [7:0] H_CMD    = 8'h00;
	localparam logic [7:0] H_STS    = 8'h04;
	localparam logic [7:0] H_FRAMES = 8'h08;
	localparam logic [7:0] H_ABORT  = 8'h0c;
	localparam logic [1:0] CMD_STOP  = 2'h1;
	localparam logic [1:0] CMD_FLUSH = 2'h2;
	localparam logic [1:0] CMD_START = 2'h3;
	localparam logic [1:0] SETTLE    = 2'h3;
	typedef enum logic [2:0] {
		SEG_IDLE = 3'b000, SEG_ROOM = 3'b001, SEG_PAYLD = 3'b011,
		SEG_SUM = 3'b010, SEG_HDR = 3'b110, SEG_DONE = 3'b111
	} lso_seg_t;
	typedef enum logic [3:0] {
		SQ_INIT = 4'b0000, SQ_IDLE = 4'b0001, SQ_FOFF = 4'b0011, SQ_FWAIT = 4'b0010,
		SQ_MOFF = 4'b0110, SQ_FLUSH = 4'b0111, SQ_FLWAIT = 4'b0101, SQ_START = 4'b0100,
		SQ_ENA = 4'b1100
	} lso_seq_t;
endpackage : lso_pkg

// ### design/lso_link_if.sv
// link between the frame fifo controller and its mac/driver controller
// assumes both ends share hclk; no clocking block
interface lso_link_if;
	logic        reg_wr;
	logic [1:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        mac_tx_off;
	logic [7:0]  tx_data;
	logic        tx_last;
	logic        tx_valid;
	logic        tx_ready;
	logic        tx_abort;
	modport dev (input reg_wr, reg_addr, reg_wdata, mac_tx_off, tx_ready, tx_abort,
		output reg_rdata, irq, tx_data, tx_last, tx_valid);
	modport ctl (output reg_wr, reg_addr, reg_wdata, mac_tx_off, tx_ready, tx_abort,
		input reg_rdata, irq, tx_data, tx_last, tx_valid);
endinterface : lso_link_if

// ### design/lso_tx_host.sv
// mac transmitter and driver sequencer facing the frame fifo controller
// assumes an AHB-Lite master with single word transfers on the same clock
module lso_tx_host (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// link to the fifo controller
	lso_link_if.ctl          link,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// bulk-out state and received frame bytes
	input  wire logic        bulk_pending,
	output logic [7:0]       mac_data,
	output logic             mac_data_valid,
	output logic             mac_data_last
);
	lso_pkg::lso_seq_t sq_reg;
	logic        wr_ph_reg, refused_reg, mac_on_reg, mac_busy_reg, abort_req_reg, abort_reg;
	logic        mac_off_reg, reg_wr_reg;
	logic [7:0]  addr_ph_reg;
	logic [31:0] wdata_reg, hrdata_reg;
	logic [1:0]  settle_reg;
	logic [15:0] frames_reg;
	logic        cmd_wr, fifo_dis, flush_busy, accept;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign cmd_wr    = wr_ph_reg && addr_ph_reg == lso_pkg::H_CMD;
	assign fifo_dis  = link.reg_rdata[lso_pkg::CTL_DIS];
	assign flush_busy = link.reg_rdata[lso_pkg::CTL_FLUSH];
	assign accept    = link.tx_valid && link.tx_ready;

	// address phase capture; reads return the value seen at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_reg <= 1'b0;
			addr_ph_reg <= '0;
			hrdata_reg <= '0;
		end else begin
			wr_ph_reg <= hsel && htrans[1] && hready && hwrite;
			addr_ph_reg <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite)
				case (haddr[7:0])
					lso_pkg::H_STS: hrdata_reg <= {26'h0, link.irq, fifo_dis, mac_on_reg,
						mac_off_reg, refused_reg, sq_reg != lso_pkg::SQ_IDLE};
					lso_pkg::H_FRAMES: hrdata_reg <= {16'h0, frames_reg};
					default: hrdata_reg <= '0;
				endcase
		end
	end

	// driver sequencer: both waits on the polled word are checked only after it has settled; the mac-off wait is not
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sq_reg <= lso_pkg::SQ_INIT;
			{refused_reg, mac_on_reg, reg_wr_reg} <= '0;
			wdata_reg <= '0;
			settle_reg <= lso_pkg::SETTLE;
		end else begin
			reg_wr_reg <= 1'b0;
			settle_reg <= (settle_reg != 2'h0) ? settle_reg - 2'h1 : 2'h0;
			if (cmd_wr && sq_reg != lso_pkg::SQ_IDLE)
				refused_reg <= 1'b1;
			case (sq_reg)
				lso_pkg::SQ_INIT: begin
					wdata_reg <= 32'h1;
					reg_wr_reg <= 1'b1;
					sq_reg <= lso_pkg::SQ_IDLE;
				end
				lso_pkg::SQ_IDLE: if (cmd_wr) begin
					refused_reg <= 1'b0;
					case (hwdata[1:0])
						lso_pkg::CMD_STOP: sq_reg <= lso_pkg::SQ_FOFF;
						lso_pkg::CMD_START: sq_reg <= lso_pkg::SQ_START;
						lso_pkg::CMD_FLUSH:
							if (fifo_dis && mac_off_reg && !bulk_pending)
								sq_reg <= lso_pkg::SQ_FLUSH;
							else
								refused_reg <= 1'b1;
						default: refused_reg <= 1'b1;
					endcase
				end
				lso_pkg::SQ_FOFF: begin
					wdata_reg <= 32'h0;
					reg_wr_reg <= 1'b1;
					settle_reg <= lso_pkg::SETTLE;
					sq_reg <= lso_pkg::SQ_FWAIT;
				end
				lso_pkg::SQ_FWAIT: if (settle_reg == 2'h0 && fifo_dis) begin
					mac_on_reg <= 1'b0;
					sq_reg <= lso_pkg::SQ_MOFF;
				end
				lso_pkg::SQ_MOFF: if (mac_off_reg)
					sq_reg <= lso_pkg::SQ_IDLE;
				lso_pkg::SQ_FLUSH: begin
					wdata_reg <= 32'h1 << lso_pkg::CTL_FLUSH;
					reg_wr_reg <= 1'b1;
					settle_reg <= lso_pkg::SETTLE;
					sq_reg <= lso_pkg::SQ_FLWAIT;
				end
				lso_pkg::SQ_FLWAIT: if (settle_reg == 2'h0 && !flush_busy)
					sq_reg <= lso_pkg::SQ_IDLE;
				lso_pkg::SQ_START: begin
					mac_on_reg <= 1'b1;
					sq_reg <= lso_pkg::SQ_ENA;
				end
				lso_pkg::SQ_ENA: begin
					wdata_reg <= 32'h1 << lso_pkg::CTL_EN;
					reg_wr_reg <= 1'b1;
					sq_reg <= lso_pkg::SQ_IDLE;
				end
				default: sq_reg <= lso_pkg::SQ_IDLE;
			endcase
		end
	end

	// irq enable goes to its own register during init; all else targets the control word
	assign link.reg_wr    = reg_wr_reg;
	assign link.reg_wdata = wdata_reg;
	assign link.reg_addr  = (sq_reg == lso_pkg::SQ_IDLE && wdata_reg == 32'h1
		&& !mac_on_reg && frames_reg == 16'h0 && reg_wr_reg) ? lso_pkg::REG_IRQ_EN
		: lso_pkg::REG_TX_CTL;

	// mac transmitter: takes bytes while enabled, can abort the frame in progress
	assign link.tx_ready   = mac_on_reg && !abort_reg;
	assign link.tx_abort   = abort_reg;
	assign link.mac_tx_off = mac_off_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{mac_busy_reg, abort_req_reg, abort_reg, mac_data_valid, mac_data_last} <= '0;
			mac_off_reg <= 1'b1;
			mac_data <= '0;
			frames_reg <= '0;
		end else begin
			mac_off_reg <= !mac_on_reg && !mac_busy_reg;
			abort_reg <= 1'b0;
			mac_data_valid <= accept;
			if (accept) begin
				mac_data <= link.tx_data;
				mac_data_last <= link.tx_last;
				mac_busy_reg <= !link.tx_last;
				if (link.tx_last)
					frames_reg <= frames_reg + 16'h1;
			end
			if (wr_ph_reg && addr_ph_reg == lso_pkg::H_ABORT && hwdata[0])
				abort_req_reg <= 1'b1;
			else if (abort_req_reg && mac_busy_reg && !accept) begin
				abort_req_reg <= 1'b0;
				abort_reg <= 1'b1;
				mac_busy_reg <= 1'b0;
			end
		end
	end
endmodule : lso_tx_host

// ### tb/lso_link_chk.sv
// checker for the segmentation link between both ends
// assumes one clock; instantiated beside the link interface
module lso_link_chk (
	// clock and reset
	input logic        hclk,
	input logic        hresetn,
	// link signals
	input logic [1:0]  reg_addr,
	input logic [31:0] reg_rdata,
	input logic        irq,
	input logic        mac_tx_off,
	input logic [7:0]  tx_data,
	input logic        tx_last,
	input logic        tx_valid,
	input logic        tx_ready,
	input logic        tx_abort
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [15:0] cnt_reg;
	logic [15:0] len_reg;
	wire         take = tx_valid && tx_ready;
	wire         ctl = reg_addr == lso_pkg::REG_TX_CTL;
	// an abort restarts or drops the frame, so the byte count starts over
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_reg <= 16'h0;
		else if (tx_abort || (take && tx_last))
			cnt_reg <= 16'h0;
		else if (take)
			cnt_reg <= cnt_reg + 16'h1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			len_reg <= 16'h0;
		else if (take && cnt_reg == 16'h0)
			len_reg[7:0] <= tx_data;
		else if (take && cnt_reg == 16'h1)
			len_reg[15:8] <= tx_data;
	end
	stream_hold_a: assert property (
		tx_valid && !tx_ready && !tx_abort |=> tx_valid && $stable(tx_data)) else $error("byte moved");
	cmd_word_a: assert property (
		take && cnt_reg == 16'h2 |-> tx_data[7:6] == 2'b11) else $error("fcs or pad clear");
	frame_len_a: assert property (
		take && tx_last |-> cnt_reg + 16'h1 == len_reg + 16'h4) else $error("bad frame length");
	disabled_frame_a: assert property (
		ctl && $rose(reg_rdata[lso_pkg::CTL_DIS]) |-> cnt_reg == 16'h0) else $error("early stop");
	flush_clear_a: assert property (
		ctl && reg_rdata[lso_pkg::CTL_FLUSH] |-> ##[1:4] (!reg_rdata[1] || !ctl)) else $error("flush stuck");
	irq_hold_a: assert property (
		$fell(irq) |-> !mac_tx_off) else $error("irq left early");
	irq_set_a: assert property (
		ctl && $rose(reg_rdata[lso_pkg::CTL_DIS]) |-> irq) else $error("no stop irq");
	abort_ready_a: assert property (
		tx_abort |=> !tx_valid) else $error("byte after abort");
endmodule : lso_link_chk

// ### tb/tx_segmentation_and_fifo_stop_test.sv
// bench: both ends on one link, ahb-lite master, job and payload driver
// assumes hreadyout answers at once; frames come back on mac_data
module tx_segmentation_and_fifo_stop_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        job_start = 1'b0;
	logic        job_ready;
	logic [15:0] mss = 16'h0010;
	logic [15:0] job_total = 16'h0;
	logic        v4 = 1'b1;
	logic        tpl_we = 1'b0;
	logic [7:0]  tpl_addr = 8'h0;
	logic [7:0]  tpl_data = 8'h0;
	logic        pl_valid = 1'b1;
	logic        pl_ready;
	logic        pl_take = 1'b0;
	logic [7:0]  pl_data = 8'h0;
	logic        bulk_pending = 1'b0;
	logic [7:0]  mac_data;
	logic        mac_data_valid;
	logic [31:0] sts;
	logic [7:0]  rx[$];
	int          errors = 0;
	int          n_compared = 0;
	lso_link_if link ();
	lso_frame_fifo_ctl lso_frame_fifo_ctl_i (.hclk(hclk), .hresetn(hresetn), .link(link),
		.job_start(job_start), .job_ready(job_ready), .job_mss(mss), .job_total(job_total),
		.job_l2_len(8'h0e), .job_vlan_len(8'h00), .job_ip_len(8'h14), .job_tcp_len(8'h14),
		.job_ipv4(v4), .job_snap(1'b0), .tpl_we(tpl_we), .tpl_addr(tpl_addr),
		.tpl_data(tpl_data), .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data));
	lso_tx_host lso_tx_host_i (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.bulk_pending(bulk_pending), .mac_data(mac_data), .mac_data_valid(mac_data_valid),
		.mac_data_last());
	lso_link_chk lso_link_chk_i (.hclk(hclk), .hresetn(hresetn), .reg_addr(link.reg_addr),
		.reg_rdata(link.reg_rdata), .irq(link.irq), .mac_tx_off(link.mac_tx_off),
		.tx_data(link.tx_data), .tx_last(link.tx_last), .tx_valid(link.tx_valid),
		.tx_ready(link.tx_ready), .tx_abort(link.tx_abort));
	always #2 hclk = ~hclk;
	// handshakes are judged at the falling edge, where ready has settled
	always @(negedge hclk) begin
		pl_take = pl_valid && pl_ready;
		if (mac_data_valid)
			rx.push_back(mac_data);
	end
	always @(posedge hclk)
		if (pl_take)
			pl_data <= pl_data + 8'h01;
	function automatic logic [7:0] tpl_byte(input int i);
		case (i)
			12: return 8'h08;
			14: return 8'h45;
			18: return 8'h12;
			19: return 8'h34;
			23: return 8'h06;
			40: return 8'h01;
			46: return 8'h50;
			47: return 8'h19;
			default: return 8'h00;
		endcase
	endfunction : tpl_byte
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		sts = hrdata;
	endtask : ahb
	// a command issued while busy is refused, so poll until idle
	task cmd(input logic [1:0] c);
		ahb(1'b1, lso_pkg::H_CMD, {30'h0, c});
		for (int i = 0; i < 600 && (i == 0 || sts[0] !== 1'b0); i++)
			ahb(1'b0, lso_pkg::H_STS, 32'h0);
	endtask : cmd
	task job(input logic [15:0] total);
		job_total <= total;
		job_start <= 1'b1;
		@(posedge hclk);
		job_start <= 1'b0;
		@(negedge hclk);
		for (int i = 0; i < 3000 && job_ready !== 1'b1; i++) @(negedge hclk);
		@(posedge hclk);
	endtask : job
	initial begin
		#100000;
		errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 54; i++) begin
			@(posedge hclk);
			tpl_we <= 1'b1;
			tpl_addr <= 8'(i);
			tpl_data <= tpl_byte(i);
		end
		@(posedge hclk);
		tpl_we <= 1'b0;
		cmd(lso_pkg::CMD_START);
		job(16'h0028);
		for (int i = 0; i < 2000 && rx.size() < 214; i++) @(posedge hclk);
		chk(32'(rx.size()), 32'd214);
		for (int k = 0; k < 3; k++) begin
			int b;
			b = 74 * k;
			chk({rx[b+1], rx[b]}, (k < 2) ? 32'd70 : 32'd62);
			chk({rx[b+20], rx[b+21]}, (k < 2) ? 32'd56 : 32'd48);
			chk({rx[b+22], rx[b+23]}, 32'h1234 + 32'(k));
			chk({rx[b+42], rx[b+43], rx[b+44], rx[b+45]}, 32'h100 + 32'(16 * k));
			chk(rx[b+51], (k < 2) ? 32'h10 : 32'h19);
		end
		$display("segmentation test done");
		cmd(lso_pkg::CMD_STOP);
		chk(sts[5:2], 4'hd);
		job(16'h0010);
		bulk_pending <= 1'b1;
		cmd(lso_pkg::CMD_FLUSH);
		chk(sts[1], 1'b1);
		bulk_pending <= 1'b0;
		cmd(lso_pkg::CMD_FLUSH);
		cmd(lso_pkg::CMD_START);
		ahb(1'b0, lso_pkg::H_STS, 32'h0);
		chk(sts[5:2], 4'h2);
		repeat (300) @(posedge hclk);
		ahb(1'b0, lso_pkg::H_FRAMES, 32'h0);
		chk(sts, 32'd3);
		$display("flush test done");
		job(16'h0028);
		cmd(lso_pkg::CMD_STOP);
		ahb(1'b0, lso_pkg::H_FRAMES, 32'h0);
		chk(sts, 32'd6);
		job(16'h0010);
		cmd(lso_pkg::CMD_START);
		repeat (300) @(posedge hclk);
		ahb(1'b0, lso_pkg::H_FRAMES, 32'h0);
		chk(sts, 32'd7);
		$display("stop and resume test done");
		summarize();
	end
endmodule : tx_segmentation_and_fifo_stop_test
